// *** logic/core_debug_pkg.sv ***
package core_debug_pkg;

    localparam int CMD_W = 10;
    localparam int WORD_W = 32;
    localparam int OPC_W = 32;
    localparam int CHAIN_W = 192;
    localparam int CTRL_W = 3;
    localparam int SYNC_W = 16;
    localparam int LEN_W = 8;

    localparam logic [6:0] SEL_CHAIN = 7'h10;
    localparam logic [6:0] SEL_NONE = 7'h11;
    localparam logic [6:0] SEL_CTRL = 7'h12;
    localparam logic [6:0] SEL_EVT = 7'h30;
    localparam logic [6:0] SEL_DCW0 = 7'h31;
    localparam int CMD_RD_BIT = 9;
    localparam logic [CMD_W-1:0] CMD_RESET = 10'h211;

    localparam int CTRL_HALT_BIT = 0;
    localparam int CTRL_WAKE_BIT = 1;
    localparam int CTRL_SBP_BIT = 2;
    localparam logic [CTRL_W-1:0] CTRL_RESET = 3'h0;
    localparam int EXT_DBG_BIT = 31;
    localparam logic [WORD_W-1:0] DCW0_RESET = 32'h0000_0000;
    localparam logic [WORD_W-1:0] EVT_RESET = 32'h1000_0000;
    localparam int EVT_SWBP_BIT = 24;

    // Crossing vector layouts
    localparam int XC_EDM = 3;
    localparam int XC_CHAIN = 4;
    localparam int LS_ENTRY = 10;
    localparam int LS_BP = 11;

    typedef enum logic [3:0] {
        TLR = 4'h0, RTI = 4'h1, SDR = 4'h3, CDR = 4'h2,
        SHDR = 4'h6, E1DR = 4'h7, PDR = 4'h4, E2DR = 4'hC,
        UDR = 4'h5, SIR = 4'hB, CIR = 4'hA, SHIR = 4'hE,
        E1IR = 4'hF, PIR = 4'h8, E2IR = 4'h9, UIR = 4'hD
    } tapState_t;

    typedef struct packed {
        logic clockActive;
        logic error;
        logic checkstop;
        logic inReset;
        logic halted;
        logic stopped;
        logic inDebug;
    } coreStatus_t;

    typedef struct packed {
        logic clockActive;
        logic error;
        logic checkstop;
        logic inReset;
        logic halted;
        logic stopped;
        logic inDebug;
        logic [1:0] zero;
        logic one;
    } statusWord_t;

endpackage : core_debug_pkg

// *** logic/core_debug_status_and_entry.sv ***
`timescale 1ns/1ps
module core_debug_status_and_entry (
    // System domain
    input wire logic clock,
    input wire logic srst,
    // Test access port, link domain
    input wire logic tck,
    input wire logic trst,
    input wire logic tms,
    input wire logic tdi,
    output logic tdo,
    output logic tdoEn,
    // Core side
    input wire core_debug_pkg::coreStatus_t coreStatus,
    input wire logic swBreakpoint,
    input wire logic [core_debug_pkg::OPC_W-1:0] nextOpcode,
    // Debug controls toward the core
    output logic haltRequest,
    output logic clockKeepAlive,
    output logic breakpointEnable,
    output logic externalDebug,
    output logic debugEvent,
    output logic stateLoad,
    output logic [core_debug_pkg::CHAIN_W-1:0] stateChain
);
    import core_debug_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    typedef struct packed {
        tapState_t tap;
        logic [CMD_W-1:0] ir;
        logic [CMD_W-1:0] cmd;
        logic [CHAIN_W-1:0] dr;
        logic [CHAIN_W-1:0] chain;
        logic chainTog;
        logic [CTRL_W-1:0] ctrl;
        logic [WORD_W-1:0] dcw0;
        logic [WORD_W-1:0] evt;
        logic [SYNC_W-1:0] s1;
        logic [SYNC_W-1:0] s2;
        logic [SYNC_W-1:0] s3;
        logic [SYNC_W-1:0] f;
        logic entSeen;
        logic bpSeen;
        logic tdo;
        logic tdoEn;
    } linkState_t;

    typedef struct packed {
        logic [SYNC_W-1:0] s1;
        logic [SYNC_W-1:0] s2;
        logic [SYNC_W-1:0] s3;
        logic [SYNC_W-1:0] f;
        logic haltReq;
        logic keepAlive;
        logic bpEn;
        logic extDbg;
        logic chainSeen;
        logic load;
        logic [CHAIN_W-1:0] chain;
        logic dbgPrev;
        logic [OPC_W-1:0] entryOp;
        logic entryTog;
        logic bpTog;
        logic bpEvt;
    } coreState_t;

    linkState_t lq;
    linkState_t ln;
    coreState_t cq;
    coreState_t cn;
    statusWord_t rawStat;
    logic [SYNC_W-1:0] linkRaw;
    logic [SYNC_W-1:0] coreRaw;
    logic [6:0] sel;
    logic [LEN_W-1:0] len;
    logic wr;
    logic [WORD_W-1:0] evtSet;
    logic [WORD_W-1:0] evtClr;

    ////////////////////////////////////////////////////////////////////////
    function automatic tapState_t tapNext(input tapState_t s, input logic m);
        case (s)
            TLR: return m ? TLR : RTI;
            RTI: return m ? SDR : RTI;
            SDR: return m ? SIR : CDR;
            CDR: return m ? E1DR : SHDR;
            SHDR: return m ? E1DR : SHDR;
            E1DR: return m ? UDR : PDR;
            PDR: return m ? E2DR : PDR;
            E2DR: return m ? UDR : SHDR;
            UDR: return m ? SDR : RTI;
            SIR: return m ? TLR : CIR;
            CIR: return m ? E1IR : SHIR;
            SHIR: return m ? E1IR : SHIR;
            E1IR: return m ? UIR : PIR;
            PIR: return m ? E2IR : PIR;
            E2IR: return m ? UIR : SHIR;
            UIR: return m ? SDR : RTI;
            default: return TLR;
        endcase
    endfunction : tapNext

    // A bit moves on only once the second and third stages agree
    function automatic logic [SYNC_W-1:0] agree(input logic [SYNC_W-1:0] a,
                                                input logic [SYNC_W-1:0] b,
                                                input logic [SYNC_W-1:0] keep);
        return (~(a ^ b) & a) | ((a ^ b) & keep);
    endfunction : agree

    function automatic logic [LEN_W-1:0] drLen(input logic [6:0] rs);
        case (rs)
            SEL_CHAIN: return LEN_W'(CHAIN_W);
            SEL_EVT: return LEN_W'(WORD_W);
            SEL_DCW0: return LEN_W'(WORD_W);
            SEL_CTRL: return LEN_W'(CTRL_W);
            default: return LEN_W'(1);
        endcase
    endfunction : drLen

    ////////////////////////////////////////////////////////////////////////
    // Link domain: TAP, command, status and data paths
    always_comb begin
        rawStat.clockActive = coreStatus.clockActive;
        rawStat.error = coreStatus.error;
        rawStat.checkstop = coreStatus.checkstop;
        rawStat.inReset = coreStatus.inReset;
        rawStat.halted = coreStatus.halted;
        rawStat.stopped = coreStatus.stopped;
        rawStat.inDebug = coreStatus.inDebug;
        rawStat.zero = 2'h0;
        rawStat.one = 1'b1;
    end

    assign linkRaw = {4'h0, cq.bpTog, cq.entryTog, rawStat};

    always_comb begin
        ln = lq;
        ln.s1 = linkRaw;
        ln.s2 = lq.s1;
        ln.s3 = lq.s2;
        ln.f = agree(lq.s2, lq.s3, lq.f);
        ln.tap = tapNext(lq.tap, tms);
        sel = lq.cmd[6:0];
        len = drLen(sel);
        wr = !lq.cmd[CMD_RD_BIT];
        evtSet = '0;
        evtClr = '0;
        // Entry opcode is held still by the core until the next entry
        if (lq.f[LS_ENTRY] != lq.entSeen) begin
            ln.entSeen = lq.f[LS_ENTRY];
            ln.chain[OPC_W-1:0] = cq.entryOp;
        end
        if (lq.f[LS_BP] != lq.bpSeen) begin
            ln.bpSeen = lq.f[LS_BP];
            evtSet[EVT_SWBP_BIT] = 1'b1;
        end
        case (lq.tap)
            TLR: begin
                ln.cmd = CMD_RESET;
            end
            CIR: begin
                ln.ir = lq.f[CMD_W-1:0];
            end
            SHIR: begin
                ln.ir = {tdi, lq.ir[CMD_W-1:1]};
            end
            UIR: begin
                ln.cmd = lq.ir;
            end
            CDR: begin
                ln.dr = '0;
                case (sel)
                    SEL_CHAIN: ln.dr = lq.chain;
                    SEL_EVT: ln.dr[WORD_W-1:0] = lq.evt;
                    SEL_DCW0: ln.dr[WORD_W-1:0] = lq.dcw0;
                    SEL_CTRL: ln.dr[CTRL_W-1:0] = lq.ctrl;
                    default: ln.dr = '0;
                endcase
            end
            SHDR: begin
                ln.dr = lq.dr >> 1;
                ln.dr[len-1] = tdi;
            end
            UDR: begin
                if (wr) begin
                    case (sel)
                        SEL_DCW0: begin
                            if (lq.dcw0[EXT_DBG_BIT]) begin
                                ln.dcw0 = lq.dr[WORD_W-1:0];
                            end else begin
                                ln.dcw0[EXT_DBG_BIT] = lq.dr[EXT_DBG_BIT];
                            end
                        end
                        SEL_EVT: begin
                            if (lq.dcw0[EXT_DBG_BIT]) begin
                                evtClr = lq.dr[WORD_W-1:0];
                            end
                        end
                        SEL_CHAIN: begin
                            if (lq.dcw0[EXT_DBG_BIT]) begin
                                ln.chain = lq.dr;
                                ln.chainTog = !lq.chainTog;
                            end
                        end
                        SEL_CTRL: ln.ctrl = lq.dr[CTRL_W-1:0];
                        default: ;
                    endcase
                end
            end
            default: ;
        endcase
        ln.evt = (lq.evt & ~evtClr) | evtSet;
        ln.tdoEn = (ln.tap == SHIR) || (ln.tap == SHDR);
        ln.tdo = (ln.tap == SHIR) ? ln.ir[0] : ln.dr[0];
        if (trst) begin
            ln = '0;
            ln.cmd = CMD_RESET;
            ln.ctrl = CTRL_RESET;
            ln.dcw0 = DCW0_RESET;
            ln.evt = EVT_RESET;
        end
    end

    always_ff @(posedge tck) begin
        lq <= ln;
    end

    ////////////////////////////////////////////////////////////////////////
    // System domain: controls toward the core and core events
    assign coreRaw = {11'h000, lq.chainTog, lq.dcw0[EXT_DBG_BIT], lq.ctrl};

    always_comb begin
        cn = cq;
        cn.s1 = coreRaw;
        cn.s2 = cq.s1;
        cn.s3 = cq.s2;
        cn.f = agree(cq.s2, cq.s3, cq.f);
        cn.haltReq = cq.f[CTRL_HALT_BIT];
        cn.keepAlive = cq.f[CTRL_WAKE_BIT];
        cn.bpEn = cq.f[CTRL_SBP_BIT];
        cn.extDbg = cq.f[XC_EDM];
        cn.chainSeen = cq.f[XC_CHAIN];
        cn.load = cq.f[XC_CHAIN] != cq.chainSeen;
        if (cn.load) begin
            cn.chain = lq.chain;
        end
        cn.dbgPrev = coreStatus.inDebug;
        if (coreStatus.inDebug && !cq.dbgPrev) begin
            cn.entryOp = nextOpcode;
            cn.entryTog = !cq.entryTog;
        end
        cn.bpEvt = swBreakpoint && cq.bpEn;
        if (cn.bpEvt) begin
            cn.bpTog = !cq.bpTog;
        end
        if (srst) begin
            cn = '0;
        end
    end

    always_ff @(posedge clock) begin
        cq <= cn;
    end

    assign tdo = lq.tdo;
    assign tdoEn = lq.tdoEn;
    assign haltRequest = cq.haltReq;
    assign clockKeepAlive = cq.keepAlive;
    assign breakpointEnable = cq.bpEn;
    assign externalDebug = cq.extDbg;
    assign debugEvent = cq.bpEvt;
    assign stateLoad = cq.load;
    assign stateChain = cq.chain;

endmodule : core_debug_status_and_entry

// *** verification/core_debug_monitor.sv ***
`timescale 1ns/1ps
module core_debug_monitor (
    // System domain
    input wire logic clock,
    input wire logic srst,
    // Link domain
    input wire logic tck,
    input wire logic trst,
    input wire logic tms,
    input wire logic tdo,
    input wire logic tdoEn,
    // Core side
    input wire logic swBreakpoint,
    input wire logic haltRequest,
    input wire logic clockKeepAlive,
    input wire logic breakpointEnable,
    input wire logic externalDebug,
    input wire logic debugEvent,
    input wire logic stateLoad,
    input wire logic [core_debug_pkg::CHAIN_W-1:0] stateChain
);
    import core_debug_pkg::*;

    reset_quiet_a: assert property (@(posedge clock) disable iff (srst)
        $fell(srst) |-> !(haltRequest || clockKeepAlive || breakpointEnable || externalDebug))
        else $error("controls not clear after reset");
    event_follows_a: assert property (@(posedge clock) disable iff (srst)
        swBreakpoint && breakpointEnable |=> debugEvent) else $error("event missing");
    event_gated_a: assert property (@(posedge clock) disable iff (srst)
        !(swBreakpoint && breakpointEnable) |=> !debugEvent) else $error("event unexpected");
    load_pulse_a: assert property (@(posedge clock) disable iff (srst)
        stateLoad |=> !stateLoad) else $error("load longer than one cycle");
    chain_guarded_a: assert property (@(posedge clock) disable iff (srst)
        $changed(stateChain) |-> stateLoad) else $error("chain changed without load");
    shift_holds_a: assert property (@(posedge tck) disable iff (trst)
        tdoEn && !tms |=> tdoEn) else $error("shift left early");
    shift_exits_a: assert property (@(posedge tck) disable iff (trst)
        tdoEn && tms |=> !tdoEn) else $error("shift kept after exit");
    tap_quiet_a: assert property (@(posedge tck) disable iff (trst)
        $fell(trst) |-> !tdoEn && !tdo) else $error("serial out active after reset");

    cover property (@(posedge clock) debugEvent);
    cover property (@(posedge clock) stateLoad);
    cover property (@(posedge clock) $rose(externalDebug));
endmodule : core_debug_monitor

bind core_debug_status_and_entry core_debug_monitor i_monitor (.clock, .srst, .tck, .trst,
    .tms, .tdo, .tdoEn, .swBreakpoint, .haltRequest, .clockKeepAlive, .breakpointEnable,
    .externalDebug, .debugEvent, .stateLoad, .stateChain);

// *** verification/core_debug_status_and_entry_test.sv ***
`timescale 1ns/1ps
module core_debug_status_and_entry_test;
    import core_debug_pkg::*;
    localparam logic [CHAIN_W-1:0] PAT = {6{32'h5AC3_0F96}};
    logic clock = 1'b0;
    logic srst = 1'b1;
    logic trst = 1'b1;
    logic tck, tms, tdi, tdo, tdoEn, haltRequest, clockKeepAlive, breakpointEnable;
    logic externalDebug, debugEvent, stateLoad;
    logic swBreakpoint = 1'b0;
    logic [OPC_W-1:0] nextOpcode = 32'h1234_ABCD;
    logic [CHAIN_W-1:0] stateChain, q;
    coreStatus_t coreStatus = '0;
    int fails = 0;
    int n_compared = 0;

    always #12.5 clock = ~clock;

    core_debug_status_and_entry i_dut (.clock, .srst, .tck, .trst, .tms, .tdi, .tdo, .tdoEn,
        .coreStatus, .swBreakpoint, .nextOpcode, .haltRequest, .clockKeepAlive,
        .breakpointEnable, .externalDebug, .debugEvent, .stateLoad, .stateChain);
    debug_tool_model i_tool (.tck, .tms, .tdi, .tdo);

    // Behavioural core: enters debug on request, clock runs while kept alive
    always @(negedge clock) begin
        coreStatus.inReset <= srst;
        coreStatus.clockActive <= clockKeepAlive;
        coreStatus.inDebug <= !srst && (coreStatus.inDebug || haltRequest);
    end

    ////////////////
    task automatic check(input string what, input logic [CHAIN_W-1:0] exp,
        input logic [CHAIN_W-1:0] got);
        n_compared++;
        if (got !== exp) begin
            fails++;
            $display("wrong value %s: expected %0h, seen %0h", what, exp, got);
        end
    endtask : check

    task automatic ir(input logic [CMD_W-1:0] c);
        logic [CMD_W-1:0] exp;
        exp = {coreStatus, 3'b001};
        i_tool.scan(1'b1, CMD_W, CHAIN_W'(c), q);
        check("status", exp, q);
    endtask : ir

    task automatic dr(input int len, input logic [CHAIN_W-1:0] d, input logic [WORD_W-1:0] exp);
        i_tool.scan(1'b0, len, d, q);
        check("scan", exp, q[WORD_W-1:0]);
        repeat (12) @(posedge clock);
    endtask : dr

    task automatic final_report();
        $display("compared %0d, failed %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : final_report

    ////////////////
    initial begin
        repeat (3) @(posedge clock);
        i_tool.walk(8'h1F, 6);
        @(negedge clock) trst = 1'b0;
        check("controls", 4'h0, {haltRequest, clockKeepAlive, breakpointEnable, externalDebug});
        ir(10'h012);
        dr(3, 3'h3, 3'h0);
        @(negedge clock) srst = 1'b0;
        repeat (12) @(posedge clock);
        check("halt wake", 2'h3, {haltRequest, clockKeepAlive});
        ir(10'h211);
        check("status word", 10'h209, q);
        ir(10'h212);
        dr(3, 3'h0, 3'h3);
        ir(10'h012);
        dr(3, 3'h6, 3'h3);
        check("ctrl", 3'h3, {haltRequest, clockKeepAlive, breakpointEnable});
        ir(10'h031);
        dr(32, 32'h7FFF_FFFF, 32'h0);
        ir(10'h030);
        dr(32, 32'hFFFF_FFFF, EVT_RESET);
        ir(10'h231);
        dr(32, 32'h0, 32'h0);
        ir(10'h031);
        dr(32, 32'h8000_0000, 32'h0);
        ir(10'h031);
        dr(32, 32'h8000_0001, 32'h8000_0000);
        ir(10'h231);
        dr(32, 32'h0, 32'h8000_0001);
        check("edm", 1'b1, externalDebug);
        @(negedge clock) swBreakpoint = 1'b1;
        @(negedge clock) swBreakpoint = 1'b0;
        ir(10'h030);
        dr(32, 32'h0FFF_FFFF, 32'h1100_0000);
        ir(10'h230);
        dr(32, 32'h0, EVT_RESET);
        ir(10'h210);
        dr(32, 32'h0, nextOpcode);
        ir(10'h010);
        dr(CHAIN_W, PAT, nextOpcode);
        check("chain", PAT, stateChain);
        ir(10'h011);
        dr(CHAIN_W, ~PAT, {~PAT[30:0], 1'b0});
        check("chain kept", PAT, stateChain);
        final_report();
    end

    initial begin
        #200000;
        fails++;
        final_report();
    end
endmodule : core_debug_status_and_entry_test

// *** verification/debug_tool_model.sv ***
`timescale 1ns/1ps
module debug_tool_model (
    // Test access port
    output logic tck,
    output logic tms,
    output logic tdi,
    input wire logic tdo
);
    import core_debug_pkg::*;

    initial begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b0;
    end

    ////////////////
    // One test clock; the clock rests low between frames
    task automatic step(input logic m, input logic d, output logic o);
        tms = m;
        tdi = d;
        o = tdo;
        #16 tck = 1'b1;
        #16 tck = 1'b0;
    endtask : step

    // Outside shifts the data line toggles so no stale level is seen
    task automatic walk(input logic [7:0] seq, input int n);
        logic o;
        for (int i = 0; i < n; i++) begin
            step(seq[i], ~tdi, o);
        end
    endtask : walk

    task automatic scan(input logic ir, input int len, input logic [CHAIN_W-1:0] d,
        output logic [CHAIN_W-1:0] q);
        q = '0;
        walk(8'h00, 6);
        walk(ir ? 8'h03 : 8'h01, ir ? 4 : 3);
        for (int i = 0; i < len; i++) begin
            step(i == len - 1, d[i], q[i]);
        end
        walk(8'h01, 2);
    endtask : scan
endmodule : debug_tool_model
